//--- design/pbs_defs.svh
// Constants for the pipelined burst SRAM core
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_LANE_W       9
`define PBS_WIDE_LANES   4
`define PBS_NARROW_LANES 2
`define PBS_WIDE_AW      19
`define PBS_NARROW_AW    20
`define PBS_FIFO_DEPTH   2
`define PBS_CNT_RST      2'h0
`define PBS_FCNT_RST     2'h0
`define PBS_FCNT_FULL    2'h2
`define PBS_SYNC_RST     3'h0
`endif

//--- design/pbs_pkg.sv
// Shared types for the pipelined burst SRAM core
package pbs_pkg;
  typedef enum logic [1:0] {
    PBS_OP_IDLE  = 2'b00,
    PBS_OP_READ  = 2'b01,
    PBS_OP_WRITE = 2'b10
  } pbs_op_t;
endpackage : pbs_pkg

//--- design/pbs_core.sv
// Pipelined burst SRAM core with two-entry read buffer
// Contract
// - Every synchronous input except rd_ready_in is captured in a register on the rising clock edge.
// - A new address and chip-select state are taken only when either address strobe is active.
// - Later burst addresses are made inside and advance only on the burst-step input.
// - The burst generator is a two-bit counter on the low address bits, wrapping within a group of four words.
// - The burst order is interleaved or linear as the mode input selects.
// - A write registers address, data and controls, then writes the array by itself.
// - Byte-lane enables qualified by the byte-write qualifier choose which lanes are written.
// - Global write low writes all lanes whatever the lane enables say.
// - Output enable and sleep act without a clock, and output enable gates the drivers directly.
// - Reads pass an output register, first word after three clocks and one per clock after.
// - A deselecting cycle releases the outputs and idles the core within one clock.
// - A sleep input gives a low-power mode in which the core does nothing.
// - The array holds 524,288 words of 36 bits or 1,048,576 words of 18 bits.
// - Address, data and command inputs and the dq_out and rd_valid_out outputs are registered, so reads and writes run as a clocked pipeline.
`include "pbs_defs.svh"
module pbs_core
  import pbs_pkg::*;
#(
  parameter  bit WIDE = 1'b1,
  localparam int NL   = WIDE ? `PBS_WIDE_LANES : `PBS_NARROW_LANES,
  localparam int DW   = NL * `PBS_LANE_W,
  localparam int AW   = WIDE ? `PBS_WIDE_AW : `PBS_NARROW_AW
) (
  input  wire logic          clock_in,
  input  wire logic          rst_b_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          chip_select_primary_n_in,
  input  wire logic          depth_select_high_in,
  input  wire logic          depth_select_low_n_in,
  input  wire logic          processor_addr_strobe_n_in,
  input  wire logic          controller_addr_strobe_n_in,
  input  wire logic          burst_step_n_in,
  input  wire logic          global_write_n_in,
  input  wire logic          byte_write_qualifier_n_in,
  input  wire logic [NL-1:0] byte_lane_write_n_in,
  input  wire logic          burst_linear_in,
  input  wire logic          output_enable_n_in,
  input  wire logic          sleep_request_in,
  input  wire logic [DW-1:0] dq_in,
  output logic      [DW-1:0] dq_out,
  output logic               dq_oe_out,
  output logic               rd_valid_out,
  input  wire logic          rd_ready_in,
  output logic               stall_out
);

  function automatic logic [NL-1:0] wr_mask(input logic gw_n, input logic bwe_n,
                                            input logic [NL-1:0] bw_n);
    wr_mask = gw_n ? (bwe_n ? '0 : ~bw_n) : '1;
  endfunction : wr_mask

  function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] base,
                                               input logic [1:0] cnt, input logic lin);
    burst_addr = {base[AW-1:2], lin ? base[1:0] + cnt : base[1:0] ^ cnt};
  endfunction : burst_addr

  // Input stage
  logic [AW-1:0] in_addr, next_in_addr;
  logic          in_ce1_n, next_in_ce1_n;
  logic          in_ce2, next_in_ce2;
  logic          in_ce3_n, next_in_ce3_n;
  logic          in_ps_n, next_in_ps_n;
  logic          in_cs_n, next_in_cs_n;
  logic          in_adv_n, next_in_adv_n;
  logic          in_gw_n, next_in_gw_n;
  logic          in_bwe_n, next_in_bwe_n;
  logic [NL-1:0] in_bw_n, next_in_bw_n;
  logic          in_lin, next_in_lin;
  logic [DW-1:0] in_data, next_in_data;
  logic          stall;

  always_comb begin
    next_in_addr  = addr_in;
    next_in_ce1_n = chip_select_primary_n_in;
    next_in_ce2   = depth_select_high_in;
    next_in_ce3_n = depth_select_low_n_in;
    next_in_ps_n  = processor_addr_strobe_n_in;
    next_in_cs_n  = controller_addr_strobe_n_in;
    next_in_adv_n = burst_step_n_in;
    next_in_gw_n  = global_write_n_in;
    next_in_bwe_n = byte_write_qualifier_n_in;
    next_in_bw_n  = byte_lane_write_n_in;
    next_in_lin   = burst_linear_in;
    next_in_data  = dq_in;
    // Holding while stalled keeps a stalled command from being overwritten
    if (stall) begin
      next_in_addr  = in_addr;
      next_in_ce1_n = in_ce1_n;
      next_in_ce2   = in_ce2;
      next_in_ce3_n = in_ce3_n;
      next_in_ps_n  = in_ps_n;
      next_in_cs_n  = in_cs_n;
      next_in_adv_n = in_adv_n;
      next_in_gw_n  = in_gw_n;
      next_in_bwe_n = in_bwe_n;
      next_in_bw_n  = in_bw_n;
      next_in_lin   = in_lin;
      next_in_data  = in_data;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_addr  <= '0;
      in_ce1_n <= 1'b1;
      in_ce2   <= 1'b0;
      in_ce3_n <= 1'b1;
      in_ps_n  <= 1'b1;
      in_cs_n  <= 1'b1;
      in_adv_n <= 1'b1;
      in_gw_n  <= 1'b1;
      in_bwe_n <= 1'b1;
      in_bw_n  <= '1;
      in_lin   <= 1'b0;
      in_data  <= '0;
    end else begin
      in_addr  <= next_in_addr;
      in_ce1_n <= next_in_ce1_n;
      in_ce2   <= next_in_ce2;
      in_ce3_n <= next_in_ce3_n;
      in_ps_n  <= next_in_ps_n;
      in_cs_n  <= next_in_cs_n;
      in_adv_n <= next_in_adv_n;
      in_gw_n  <= next_in_gw_n;
      in_bwe_n <= next_in_bwe_n;
      in_bw_n  <= next_in_bw_n;
      in_lin   <= next_in_lin;
      in_data  <= next_in_data;
    end
  end

  // Sleep synchroniser, a level counts once the last two stages agree
  logic [2:0] sync, next_sync;
  logic       asleep, next_asleep;

  always_comb begin
    next_sync   = {sync[1:0], sleep_request_in};
    next_asleep = (sync[2] == sync[1]) ? sync[2] : asleep;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync   <= `PBS_SYNC_RST;
      asleep <= 1'b0;
    end else begin
      sync   <= next_sync;
      asleep <= next_asleep;
    end
  end

  // Command decode on the registered inputs
  logic          selected, ps_start, strobe, start, deselect, flush, live;
  logic          step, start_go, step_go;
  logic [NL-1:0] in_mask;
  pbs_op_t       kind;

  always_comb begin
    selected = !in_ce1_n && in_ce2 && !in_ce3_n;
    // Processor strobe is ignored while the primary select is high
    ps_start = !in_ps_n && !in_ce1_n;
    strobe   = ps_start || !in_cs_n;
    start    = strobe && selected;
    deselect = strobe && !selected;
    flush    = deselect || asleep;
    in_mask  = wr_mask(in_gw_n, in_bwe_n, in_bw_n);
    step     = !in_adv_n && !strobe && live;
    kind     = (!ps_start && in_mask != '0) ? PBS_OP_WRITE : PBS_OP_READ;
    if (step) begin
      kind = (in_mask != '0) ? PBS_OP_WRITE : PBS_OP_READ;
    end
    start_go = start && !stall && !asleep;
    step_go  = step && !stall && !asleep;
  end

  // Operation stage
  pbs_op_t       op_q, next_op_q;
  logic [AW-1:0] base_addr, next_base_addr, cur_addr;
  logic [1:0]    cnt, next_cnt;
  logic          next_live;
  logic [DW-1:0] wdata_q, next_wdata_q;
  logic [NL-1:0] mask_q, next_mask_q;

  always_comb begin
    next_op_q      = PBS_OP_IDLE;
    next_base_addr = base_addr;
    next_cnt       = cnt;
    next_live      = live;
    next_wdata_q   = wdata_q;
    next_mask_q    = '0;
    if (flush) begin
      next_live = 1'b0;
    end else if (stall) begin
      next_op_q   = op_q;
      next_mask_q = mask_q;
    end else if (start) begin
      next_base_addr = in_addr;
      next_cnt       = `PBS_CNT_RST;
      next_live      = 1'b1;
      next_op_q      = kind;
      next_wdata_q   = in_data;
      next_mask_q    = (kind == PBS_OP_WRITE) ? in_mask : '0;
    end else if (step) begin
      next_cnt     = cnt + 2'h1;
      next_op_q    = kind;
      next_wdata_q = in_data;
      next_mask_q  = (kind == PBS_OP_WRITE) ? in_mask : '0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_q      <= PBS_OP_IDLE;
      base_addr <= '0;
      cnt       <= `PBS_CNT_RST;
      live      <= 1'b0;
      wdata_q   <= '0;
      mask_q    <= '0;
    end else begin
      op_q      <= next_op_q;
      base_addr <= next_base_addr;
      cnt       <= next_cnt;
      live      <= next_live;
      wdata_q   <= next_wdata_q;
      mask_q    <= next_mask_q;
    end
  end

  assign cur_addr = burst_addr(base_addr, cnt, in_lin);

  // Array stage; the array is flip-flops, so a full build is very large
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] new_word;
  logic          do_read, do_write;

  always_comb begin
    do_read  = 1'b0;
    do_write = 1'b0;
    unique case (op_q)
      PBS_OP_IDLE:  ;
      PBS_OP_READ:  do_read = 1'b1;
      PBS_OP_WRITE: do_write = 1'b1;
      default:      ;
    endcase
  end

  for (genvar l = 0; l < NL; l++) begin : g_lane
    assign new_word[l*`PBS_LANE_W +: `PBS_LANE_W] = mask_q[l] ?
      wdata_q[l*`PBS_LANE_W +: `PBS_LANE_W] : mem[cur_addr][l*`PBS_LANE_W +: `PBS_LANE_W];
  end

  always_ff @(posedge clock_in) begin
    if (do_write) begin
      mem[cur_addr] <= new_word;
    end
  end

  // Two-entry read buffer, doubling as the output register
  logic [DW-1:0] fifo [`PBS_FIFO_DEPTH];
  logic [DW-1:0] next_fifo [`PBS_FIFO_DEPTH];
  logic [1:0]    fcnt, next_fcnt;
  logic          wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic          pop, push;

  always_comb begin
    pop   = rd_valid_out && rd_ready_in;
    stall = do_read && (fcnt == `PBS_FCNT_FULL) && !pop && !flush;
    push  = do_read && !stall && !flush;
    next_wr_ptr = push ? !wr_ptr : wr_ptr;
    next_rd_ptr = pop ? !rd_ptr : rd_ptr;
    next_fcnt   = fcnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      next_wr_ptr = 1'b0;
      next_rd_ptr = 1'b0;
      next_fcnt   = `PBS_FCNT_RST;
    end
  end

  for (genvar e = 0; e < `PBS_FIFO_DEPTH; e++) begin : g_entry
    assign next_fifo[e] = (push && wr_ptr == e[0]) ? mem[cur_addr] : fifo[e];
    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        fifo[e] <= '0;
      end else begin
        fifo[e] <= next_fifo[e];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fcnt   <= `PBS_FCNT_RST;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      fcnt   <= next_fcnt;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  assign dq_out       = fifo[rd_ptr];
  assign rd_valid_out = fcnt != `PBS_FCNT_RST;
  // Raw pins gate the drivers so release needs no clock
  assign dq_oe_out    = rd_valid_out && !output_enable_n_in && !sleep_request_in;
  assign stall_out    = stall;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_input_capture: assert property (
    $past(rst_b_in) && !$past(stall) |-> in_addr == $past(addr_in) &&
      in_gw_n == $past(global_write_n_in))
    else $error("input register missed its sample");
  a_strobe_load: assert property (
    start_go |=> base_addr == $past(in_addr) && cnt == 2'h0 && live)
    else $error("strobe did not load the address");
  a_burst_hold: assert property (
    !stall && !start && !step |=> cnt == $past(cnt))
    else $error("burst counter moved without a step");
  a_count_wrap: assert property (
    step_go && !deselect && cnt == 2'h3 |=> cnt == 2'h0 && base_addr == $past(base_addr))
    else $error("burst counter did not wrap in its group");
  a_linear_order: assert property (
    step_go && !deselect && in_lin |=>
      !in_lin || cur_addr[1:0] == $past(cur_addr[1:0]) + 2'h1)
    else $error("linear burst did not step by one");
  a_global_write: assert property (
    start_go && !ps_start && !in_gw_n |=> ##2 mem[$past(in_addr, 3)] == $past(in_data, 3))
    else $error("global write did not store the whole word");
  a_byte_mask: assert property (
    start_go && !ps_start && in_gw_n && !in_bwe_n && in_bw_n != '1 |=>
      mask_q == ~$past(in_bw_n) && op_q == PBS_OP_WRITE)
    else $error("byte lanes not taken from the lane enables");
  a_oe_async: assert property (
    output_enable_n_in || sleep_request_in |-> !dq_oe_out)
    else $error("drivers on while disabled");
  a_read_latency: assert property (
    start_go && kind == PBS_OP_READ ##1 !flush |=> rd_valid_out)
    else $error("read word late");
  a_deselect_idle: assert property (
    deselect |=> !rd_valid_out && !dq_oe_out && !live && op_q == PBS_OP_IDLE)
    else $error("deselect did not idle the core");
  a_sleep_quiet: assert property (
    asleep |=> !rd_valid_out && op_q == PBS_OP_IDLE)
    else $error("core active in sleep");
  a_stall_hold: assert property (
    stall |=> $stable(in_addr) && op_q == $past(op_q) && fcnt == `PBS_FCNT_FULL)
    else $error("stall lost pipeline state");

  c_burst_four: cover property (step_go && cnt == 2'h2 ##1 step_go);
  c_write: cover property (do_write && mask_q != '1 && mask_q != '0);
  c_deselect: cover property (rd_valid_out ##1 deselect);
  c_stall: cover property (stall [*2] ##1 pop);

endmodule : pbs_core

//--- tb/pbs_sink.sv
// Read-data receiver model that can accept at once or hold off
module pbs_sink (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        hold_in,
  input  wire logic        valid_in,
  input  wire logic [35:0] data_in,
  output logic             ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] seen [0:63];
  int          cnt;
  // Holding off is how the bench fills the buffer
  assign ready_out = !hold_in;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 0;
    end else if (valid_in && ready_out) begin
      seen[cnt % 64] <= data_in;
      cnt            <= cnt + 1;
    end
  end
endmodule : pbs_sink

//--- tb/testbench.sv
// Self-checking bench for the pipelined burst core
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [18:0] BASE = 19'h00104;
  localparam logic [35:0] NEWD = 36'h0FEDCBA98;
  logic        clk, rst_b, cs_n, ds_hi, ds_lo_n, pr_n, ct_n, st_n, gw_n, bq_n, lin, oe_n;
  logic        sleep, hold, dq_oe, rd_valid, rd_ready, stall;
  logic [3:0]  lanes_n;
  logic [18:0] addr;
  logic [35:0] dq_in, dq_out;
  int          mismatches, tests_run;
  pbs_core #(.WIDE(1'b1)) DUT (
    .clock_in(clk), .rst_b_in(rst_b), .addr_in(addr), .chip_select_primary_n_in(cs_n),
    .depth_select_high_in(ds_hi), .depth_select_low_n_in(ds_lo_n),
    .processor_addr_strobe_n_in(pr_n), .controller_addr_strobe_n_in(ct_n),
    .burst_step_n_in(st_n), .global_write_n_in(gw_n), .byte_write_qualifier_n_in(bq_n),
    .byte_lane_write_n_in(lanes_n), .burst_linear_in(lin), .output_enable_n_in(oe_n),
    .sleep_request_in(sleep), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe),
    .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .stall_out(stall));
  pbs_sink u_sink (.clock_in(clk), .rst_b_in(rst_b), .hold_in(hold), .valid_in(rd_valid),
    .data_in(dq_out), .ready_out(rd_ready));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [35:0] wd(input int i);
    return 36'h912345600 + 36'(i);
  endfunction : wd
  task results;
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task cmp_word(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task edges(input int n);
    repeat (n) @(posedge clk);
  endtask : edges
  // Holds the command until an edge where the core is not stalled takes it
  task cmd(input logic [18:0] a, input logic c, p, s, g, q, input logic [3:0] ln,
           input logic [35:0] d, input logic on);
    int   n;
    logic st;
    addr <= a; ct_n <= c; pr_n <= p; st_n <= s; gw_n <= g; bq_n <= q; lanes_n <= ln;
    dq_in <= d; cs_n <= !on; ds_hi <= on; ds_lo_n <= !on;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      st = stall;
      @(posedge clk);
      if (st !== 1'b1) break;
    end
    if (n == 50) begin
      mismatches++;
      results();
    end
  endtask : cmd
  task idle;
    ct_n <= 1'b1; pr_n <= 1'b1; st_n <= 1'b1; gw_n <= 1'b1; bq_n <= 1'b1;
    lanes_n <= 4'hF; dq_in <= ~dq_in;
    @(posedge clk);
  endtask : idle
  task step;
    cmd(BASE, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, dq_in, 1'b1);
  endtask : step
  task t_write_all;
    for (int i = 0; i < 4; i++)
      cmd(BASE + 19'(i), 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, wd(i), 1'b1);
    idle();
  endtask : t_write_all
  task t_burst(input logic l, input int off);
    int n0;
    n0 = u_sink.cnt;
    lin <= l;
    cmd(BASE + 19'(off), 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, dq_in, 1'b1);
    step();
    #1 cmp_bit(rd_valid, 1'b0);
    step();
    #1 cmp_bit(rd_valid, 1'b1);
    step();
    // A fourth step wraps back to the starting word of the burst
    step();
    idle();
    edges(6);
    cmp_bit(u_sink.cnt == n0 + 5, 1'b1);
    for (int k = 0; k < 5; k++)
      cmp_word(u_sink.seen[(n0+k)%64], wd(l ? (off+k)%4 : off^(k%4)));
  endtask : t_burst
  task t_stall;
    int n0;
    n0 = u_sink.cnt;
    hold <= 1'b1;
    lin <= 1'b1;
    cmd(BASE, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, dq_in, 1'b1);
    repeat (3) step();
    idle();
    edges(4);
    #1 cmp_bit(stall, 1'b1);
    cmp_bit(rd_valid, 1'b1);
    hold <= 1'b0;
    edges(10);
    for (int k = 0; k < 4; k++) cmp_word(u_sink.seen[(n0+k)%64], wd(k));
  endtask : t_stall
  task t_desel;
    hold <= 1'b1;
    cmd(BASE, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, dq_in, 1'b1);
    idle();
    edges(4);
    #1 cmp_bit(rd_valid, 1'b1);
    cmd(BASE, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, dq_in, 1'b0);
    idle();
    #1 cmp_bit(rd_valid, 1'b0);
    cmp_bit(dq_oe, 1'b0);
    hold <= 1'b0;
    @(posedge clk);
  endtask : t_desel
  task t_async;
    hold <= 1'b1;
    cmd(BASE + 19'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, dq_in, 1'b1);
    idle();
    edges(4);
    #1 cmp_bit(dq_oe, 1'b1);
    oe_n <= 1'b1;
    #1 cmp_bit(dq_oe, 1'b0);
    oe_n <= 1'b0;
    #1 cmp_bit(dq_oe, 1'b1);
    sleep <= 1'b1;
    #1 cmp_bit(dq_oe, 1'b0);
    edges(5);
    #1 cmp_bit(rd_valid, 1'b0);
    sleep <= 1'b0;
    hold <= 1'b0;
    edges(5);
  endtask : t_async
  task rd1(input logic p, input logic [35:0] exp);
    int n0;
    n0 = u_sink.cnt;
    // Processor strobe start carries live write enables that must be ignored
    cmd(BASE + 19'h2, p, !p, 1'b1, !p, 1'b1, p ? 4'h0 : 4'hF, 36'h0, 1'b1);
    idle();
    edges(5);
    cmp_word(u_sink.seen[n0%64], exp);
  endtask : rd1
  task t_bytes;
    logic [35:0] mix;
    mix        = wd(2);
    mix[26:18] = NEWD[26:18];
    mix[8:0]   = NEWD[8:0];
    cmd(BASE + 19'h2, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'b1010, NEWD, 1'b1);
    idle();
    rd1(1'b1, mix);
    rd1(1'b0, mix);
  endtask : t_bytes
  initial begin
    mismatches = 0; tests_run = 0; rst_b = 1'b0; hold = 1'b0; addr = '0;
    cs_n = 1'b1; ds_hi = 1'b0; ds_lo_n = 1'b1; pr_n = 1'b1; ct_n = 1'b1; st_n = 1'b1;
    gw_n = 1'b1; bq_n = 1'b1; lanes_n = 4'hF; lin = 1'b1; oe_n = 1'b0; sleep = 1'b0;
    dq_in = 36'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_write_all();
    t_burst(1'b1, 1);
    t_burst(1'b0, 1);
    t_burst(1'b0, 2);
    t_stall();
    t_desel();
    t_async();
    t_bytes();
    results();
  end
endmodule : testbench
